//--- common/mca_defines.svh
// constants for the commissioning and addressing command interpreter
// assumes a 10 MHz ref_clk and standard modbus rtu framing outside
`ifndef MCA_DEFINES_SVH
`define MCA_DEFINES_SVH

`define MCA_CLK_HZ          10000000
`define MCA_DEBOUNCE_MS     10
`define MCA_DEBOUNCE_CYC    (`MCA_DEBOUNCE_MS * (`MCA_CLK_HZ / 1000))

`define MCA_BCAST_ADDR      8'hff
`define MCA_FC_READ         8'h03
`define MCA_FC_WRITE        8'h06
`define MCA_FC_EXC_BIT      8'h80

`define MCA_IDX_DEFAULTS    16'h00bb
`define MCA_IDX_CUR_ADDR    16'h00bc
`define MCA_IDX_NEW_ADDR    16'h00bd
`define MCA_DEFAULTS_VAL    16'h0000
`define MCA_READ_QTY        16'h0001
`define MCA_READ_BYTES      8'h02

`define MCA_EXC_FUNC        8'h01
`define MCA_EXC_INDEX       8'h02
`define MCA_EXC_SWITCH      8'h08

`define MCA_CRC_INIT        16'hffff
`define MCA_CRC_POLY        16'ha001
`define MCA_ADDR_RST        8'h01

`define MCA_MIN_FRAME       4'h4
`define MCA_REQ_LEN         4'h8
`define MCA_LEN_EXC         3'h3
`define MCA_LEN_READ        3'h5
`define MCA_LEN_ECHO        3'h6

`endif

//--- common/mca_pkg.sv
// types shared by the command interpreter files
// assumes nothing beyond the defines header
package mca_pkg;
   typedef enum logic [4:0] {
      MCA_S_RX    = 5'b00001,
      MCA_S_TX    = 5'b00010,
      MCA_S_CRCL  = 5'b00100,
      MCA_S_CRCH  = 5'b01000,
      MCA_S_DRAIN = 5'b10000
   } mca_state_e;
   typedef logic [7:0] mca_byte_t;
endpackage

//--- rtl/mca_crc16_step.sv
// one byte step of the modbus rtu crc-16
// assumes the caller holds the running value in its own register
`timescale 1ns/10ps
`include "mca_defines.svh"
module mca_crc16_step
   import mca_pkg::*;
(
   input  wire logic [15:0] crc_in,
   input  wire mca_byte_t   data,
   output logic      [15:0] crc_out
);
   logic [15:0] c;

   // reflected polynomial, lsb first
   always_comb
   begin
      c = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         if (c[0])
            c = (c >> 1) ^ `MCA_CRC_POLY;
         else
            c = c >> 1;
      end
      crc_out = c;
   end
endmodule

//--- rtl/mca_core.sv
// modbus commissioning and addressing command interpreter, slave side
// assumes an outside uart delivers received bytes with a frame end
// strobe and an error flag, and takes reply bytes by valid/ready
`timescale 1ns/10ps
`include "mca_defines.svh"
module mca_core
   import mca_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = `MCA_DEBOUNCE_CYC
)
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire mca_byte_t  rx_byte,
   input  wire logic       rx_valid,
   input  wire logic       rx_err,
   input  wire logic       rx_end,
   input  wire logic       addr_enable_sw,
   input  wire logic       tx_ready,
   output mca_byte_t       tx_byte,
   output logic            tx_valid,
   output logic            tx_last,
   output mca_byte_t       slave_addr,
   output logic            defaults_pulse,
   output logic            sw_enabled
);

   ////////////////////////////////////////////////////////////////////
   mca_state_e  state_ff;
   mca_byte_t   rbuf_ff [8];
   logic [3:0]  cnt_ff;
   logic        err_ff;
   logic [15:0] rx_crc_ff;
   logic [15:0] nxt_rx_crc;
   mca_byte_t   tbuf_ff [6];
   logic [2:0]  tlen_ff;
   logic [2:0]  idx_ff;
   logic [15:0] tx_crc_ff;
   logic [15:0] nxt_tx_crc;
   mca_byte_t   tx_byte_ff;
   logic        tx_valid_ff;
   logic        tx_last_ff;
   mca_byte_t   addr_ff;
   logic        defaults_ff;
   logic        sw_meta_ff;
   logic        sw_sync_ff;
   logic        sw_stable_ff;
   logic [19:0] deb_cnt_ff;

   mca_crc16_step u_rx_crc
   (
      .crc_in  (rx_crc_ff),
      .data    (rx_byte),
      .crc_out (nxt_rx_crc)
   );

   mca_crc16_step u_tx_crc
   (
      .crc_in  (tx_crc_ff),
      .data    (tbuf_ff[idx_ff]),
      .crc_out (nxt_tx_crc)
   );

   ////////////////////////////////////////////////////////////////////
   // address switch: two-stage sync, then hold-off counter
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sw_meta_ff   <= 1'b0;
         sw_sync_ff   <= 1'b0;
         sw_stable_ff <= 1'b0;
         deb_cnt_ff   <= 20'h00000;
      end
      else
      begin
         sw_meta_ff <= addr_enable_sw;
         sw_sync_ff <= sw_meta_ff;
         if (sw_sync_ff == sw_stable_ff)
            deb_cnt_ff <= 20'h00000;
         else if (deb_cnt_ff >= 20'(DEBOUNCE_CYCLES - 1))
         begin
            sw_stable_ff <= sw_sync_ff;
            deb_cnt_ff   <= 20'h00000;
         end
         else
            deb_cnt_ff <= deb_cnt_ff + 20'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // request decode at frame end
   mca_byte_t   fc;
   logic [15:0] idx;
   logic [15:0] val;
   logic        frame_ok;
   logic        go;
   logic        do_defaults;
   logic        do_addr;
   logic [2:0]  r_len;
   mca_byte_t   r_b [6];

   assign fc  = rbuf_ff[1];
   assign idx = {rbuf_ff[2], rbuf_ff[3]};
   assign val = {rbuf_ff[4], rbuf_ff[5]};
   // bad frames and frames for other addresses get no answer
   assign frame_ok = rx_end && state_ff == MCA_S_RX && !err_ff && !rx_err &&
                     cnt_ff >= `MCA_MIN_FRAME && cnt_ff <= `MCA_REQ_LEN &&
                     rx_crc_ff == 16'h0000 &&
                     rbuf_ff[0] == `MCA_BCAST_ADDR;

   always_comb
   begin
      go          = 1'b0;
      do_defaults = 1'b0;
      do_addr     = 1'b0;
      r_len       = `MCA_LEN_EXC;
      r_b[0]      = `MCA_BCAST_ADDR;
      r_b[1]      = fc | `MCA_FC_EXC_BIT;
      r_b[2]      = `MCA_EXC_FUNC;
      r_b[3]      = rbuf_ff[3];
      r_b[4]      = rbuf_ff[4];
      r_b[5]      = rbuf_ff[5];
      if (frame_ok)
      begin
         go = 1'b1;
         if (fc != `MCA_FC_READ && fc != `MCA_FC_WRITE)
            r_b[2] = `MCA_EXC_FUNC;
         else if (cnt_ff != `MCA_REQ_LEN)
            go = 1'b0; // short request is a format error
         else if (!sw_stable_ff)
            r_b[2] = `MCA_EXC_SWITCH; // nothing acted on
         else if (fc == `MCA_FC_READ)
         begin
            if (idx == `MCA_IDX_CUR_ADDR && val == `MCA_READ_QTY)
            begin
               r_len  = `MCA_LEN_READ;
               r_b[1] = fc;
               r_b[2] = `MCA_READ_BYTES;
               r_b[3] = 8'h00;
               r_b[4] = addr_ff;
            end
            else
               r_b[2] = `MCA_EXC_INDEX;
         end
         else if (idx == `MCA_IDX_DEFAULTS && val == `MCA_DEFAULTS_VAL)
         begin
            do_defaults = 1'b1;
            r_len       = `MCA_LEN_ECHO;
            r_b[1]      = fc;
            r_b[2]      = rbuf_ff[2];
         end
         else if (idx == `MCA_IDX_NEW_ADDR && val[15:8] == 8'h00)
         begin
            do_addr = 1'b1;
            r_len   = `MCA_LEN_ECHO;
            r_b[1]  = fc;
            r_b[2]  = rbuf_ff[2];
         end
         else
            r_b[2] = `MCA_EXC_INDEX;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receive collection; bytes arriving while a reply goes out are lost
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_ff    <= 4'h0;
         err_ff    <= 1'b0;
         rx_crc_ff <= `MCA_CRC_INIT;
         for (int i = 0; i < 8; i++)
            rbuf_ff[i] <= 8'h00;
      end
      else if (state_ff != MCA_S_RX || rx_end)
      begin
         cnt_ff    <= 4'h0;
         err_ff    <= 1'b0;
         rx_crc_ff <= `MCA_CRC_INIT;
      end
      else
      begin
         if (rx_err)
            err_ff <= 1'b1;
         if (rx_valid)
         begin
            if (cnt_ff < `MCA_REQ_LEN)
               rbuf_ff[cnt_ff[2:0]] <= rx_byte;
            if (cnt_ff <= `MCA_REQ_LEN)
               cnt_ff <= cnt_ff + 4'h1;
            rx_crc_ff <= nxt_rx_crc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stored address and defaults strobe
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         addr_ff     <= `MCA_ADDR_RST;
         defaults_ff <= 1'b0;
      end
      else
      begin
         defaults_ff <= do_defaults;
         if (do_addr)
            addr_ff <= val[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reply sender: body bytes, then crc low, then crc high
   logic can_load;
   assign can_load = !tx_valid_ff || tx_ready;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff    <= MCA_S_RX;
         tlen_ff     <= 3'h0;
         idx_ff      <= 3'h0;
         tx_crc_ff   <= `MCA_CRC_INIT;
         tx_byte_ff  <= 8'h00;
         tx_valid_ff <= 1'b0;
         tx_last_ff  <= 1'b0;
         for (int i = 0; i < 6; i++)
            tbuf_ff[i] <= 8'h00;
      end
      else
      begin
         unique case (state_ff)
            MCA_S_RX:
            begin
               if (go)
               begin
                  tbuf_ff   <= r_b;
                  tlen_ff   <= r_len;
                  idx_ff    <= 3'h0;
                  tx_crc_ff <= `MCA_CRC_INIT;
                  state_ff  <= MCA_S_TX;
               end
            end
            MCA_S_TX:
            begin
               if (can_load)
               begin
                  tx_byte_ff  <= tbuf_ff[idx_ff];
                  tx_valid_ff <= 1'b1;
                  tx_crc_ff   <= nxt_tx_crc;
                  idx_ff      <= idx_ff + 3'h1;
                  if (idx_ff == tlen_ff - 3'h1)
                     state_ff <= MCA_S_CRCL;
               end
            end
            MCA_S_CRCL:
            begin
               if (can_load)
               begin
                  tx_byte_ff <= tx_crc_ff[7:0];
                  state_ff   <= MCA_S_CRCH;
               end
            end
            MCA_S_CRCH:
            begin
               if (can_load)
               begin
                  tx_byte_ff <= tx_crc_ff[15:8];
                  tx_last_ff <= 1'b1;
                  state_ff   <= MCA_S_DRAIN;
               end
            end
            MCA_S_DRAIN:
            begin
               if (tx_ready)
               begin
                  tx_valid_ff <= 1'b0;
                  tx_last_ff  <= 1'b0;
                  state_ff    <= MCA_S_RX;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign tx_byte        = tx_byte_ff;
   assign tx_valid       = tx_valid_ff;
   assign tx_last        = tx_last_ff;
   assign slave_addr     = addr_ff;
   assign defaults_pulse = defaults_ff;
   assign sw_enabled     = sw_stable_ff;
endmodule

//--- tb/mca_core_properties.sv
// port assertions for the command interpreter
// assumes the single ref_clk domain and async reset of mca_core
`timescale 1ns/10ps
module mca_core_checker
   import mca_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = 4
)
(
   input wire logic      ref_clk,
   input wire logic      reset,
   input wire logic      rx_err,
   input wire logic      rx_end,
   input wire logic      addr_enable_sw,
   input wire logic      tx_ready,
   input wire mca_byte_t tx_byte,
   input wire logic      tx_valid,
   input wire logic      tx_last,
   input wire mca_byte_t slave_addr,
   input wire logic      defaults_pulse,
   input wire logic      sw_enabled
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   int hi_ff;
   // raw switch run length, so a short glitch cannot enable commands
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         hi_ff <= 0;
      else
         hi_ff <= addr_enable_sw ? hi_ff + 1 : 0;
   end
   a_reply_delay: assert property (
      $rose(tx_valid) |-> $past(rx_end, 2)) else $error("late reply");
   a_fixed_addr: assert property (
      $rose(tx_valid) |-> tx_byte == 8'hff) else $error("bad address");
   a_stall_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)
         && $stable(tx_last)) else $error("reply not held");
   a_last_ends: assert property (
      tx_valid && tx_ready && tx_last |=> !tx_valid) else $error("no end");
   a_err_quiet: assert property (
      rx_end && rx_err && !tx_valid |=> !tx_valid [*2])
      else $error("reply to bad frame");
   a_pulse_gate: assert property (
      defaults_pulse |-> $past(rx_end) && sw_enabled ##1 !defaults_pulse)
      else $error("bad defaults pulse");
   a_addr_gate: assert property (
      !$stable(slave_addr) |-> $past(rx_end) && sw_enabled)
      else $error("address changed");
   a_sw_debounce: assert property (
      $rose(sw_enabled) |-> hi_ff >= DEBOUNCE_CYCLES)
      else $error("switch not debounced");
endmodule
////////////////////////////////////////////////////////////////////////
bind mca_core mca_core_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_chk
(
   .ref_clk(ref_clk), .reset(reset), .rx_err(rx_err), .rx_end(rx_end),
   .addr_enable_sw(addr_enable_sw), .tx_ready(tx_ready),
   .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last),
   .slave_addr(slave_addr), .defaults_pulse(defaults_pulse),
   .sw_enabled(sw_enabled)
);

//--- tb/mca_master_model.sv
// master side of the link: takes reply bytes, may stall
// assumes the bench pulses clr before each request
`timescale 1ns/10ps
module mca_master_model
   import mca_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      reset,
   input  wire logic      clr,
   input  wire logic      slow,
   input  wire mca_byte_t tx_byte,
   input  wire logic      tx_valid,
   output logic           tx_ready,
   output mca_byte_t      got [16],
   output logic [4:0]     n
);
   // slow takes every other cycle only, to exercise the hold
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         tx_ready <= 1'b0;
      else
         tx_ready <= !slow || !tx_ready;
   end
   always_ff @(posedge ref_clk)
   begin
      if (clr)
         n <= 5'h00;
      else if (tx_valid && tx_ready)
      begin
         got[n[3:0]] <= tx_byte;
         n <= n + 5'h01;
      end
   end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the command interpreter
// assumes the master model and checker files compiled before it
`timescale 1ns/10ps
module tb_top
   import mca_pkg::*;
;
   logic       ref_clk, reset, rx_valid, rx_err, rx_end, sw, clr, slow;
   logic       tx_valid, tx_ready, tx_last, defaults_pulse, sw_enabled;
   mca_byte_t  rx_byte, tx_byte, slave_addr, rnd;
   mca_byte_t  got [16];
   mca_byte_t  bad_fc [4] = '{8'h01, 8'h04, 8'h10, 8'h2b};
   logic [4:0] n, last_at;
   logic [7:0] q[$], e[$];
   int         fails, check_count, pulses;
   mca_core #(.DEBOUNCE_CYCLES(4)) i_dut (.ref_clk(ref_clk),
      .reset(reset), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .rx_err(rx_err), .rx_end(rx_end), .addr_enable_sw(sw),
      .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .tx_last(tx_last), .slave_addr(slave_addr),
      .defaults_pulse(defaults_pulse), .sw_enabled(sw_enabled));
   mca_master_model i_mst (.ref_clk(ref_clk), .reset(reset), .clr(clr),
      .slow(slow), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .got(got), .n(n));
   ////////////////////////////////////////////////////////////////////
   function automatic mca_byte_t lfsr(mca_byte_t s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [15:0] crc16(logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i])
      begin
         c = c ^ {8'h00, b[i]};
         repeat (8)
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(logic [7:0] a, logic [7:0] b);
      check_count++;
      if (a !== b)
      begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, a, b);
      end
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   // kind 0 silent (p 1 crc fault, p 2 line fault, p 3 line fault at
   // frame end only, p 4 other slave address), 1 exception code p,
   // 2 read giving p, 3 echo
   task automatic xfer(logic [7:0] fc, logic [15:0] idx, val,
                       int kind, logic [7:0] p);
      logic [15:0] c;
      q = {8'hff, fc, idx[15:8], idx[7:0], val[15:8], val[7:0]};
      q[0] = q[0] ^ 8'(kind == 0 && p == 4);
      c = crc16(q);
      q.push_back(c[7:0] ^ 8'(kind == 0 && p == 1));
      q.push_back(c[15:8]);
      case (kind)
         1: e = {8'hff, fc | 8'h80, p};
         2: e = {8'hff, 8'h03, 8'h02, 8'h00, p};
         3: e = q[0:5];
         default: e = {};
      endcase
      c = crc16(e);
      if (kind != 0)
         e = {e, c[7:0], c[15:8]};
      tick();
      clr = 1;
      rx_err = (kind == 0 && p == 2);
      tick();
      clr = 0;
      foreach (q[i])
      begin
         rx_valid = 1;
         rx_byte = q[i];
         tick();
      end
      rx_valid = 0;
      rx_byte = ~rx_byte;
      rx_end = 1;
      rx_err = rx_err || (kind == 0 && p == 3);
      tick();
      rx_end = 0;
      rx_err = 0;
      for (int k = 0; k < 100; k++)
      begin
         tick();
         if (kind == 0 && k == 20)
            break;
         if (kind != 0 && n == e.size() && tx_valid === 1'b0)
            break;
         if (k == 99)
         begin
            fails++;
            stop_test();
         end
      end
      chk(8'(n), 8'(e.size()));
      chk(8'(last_at), kind != 0 ? 8'(e.size() - 1) : 8'h1f);
      foreach (e[i])
         chk(got[i], e[i]);
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk)
      if (defaults_pulse === 1'b1)
         pulses++;
   // index of the byte that carried tx_last, 1f when none did
   always @(posedge ref_clk)
      if (clr)
         last_at <= 5'h1f;
      else if (tx_valid && tx_ready && tx_last === 1'b1)
         last_at <= n;
   initial
   begin
      ref_clk = 0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial
   begin
      {reset, rx_valid, rx_err, rx_end, sw, clr, slow} = 7'h40;
      rx_byte = 8'h00;
      fails = 0;
      check_count = 0;
      pulses = 0;
      rnd = 8'h38;
      repeat (4) @(posedge ref_clk);
      #1;
      reset = 0;
      chk(slave_addr, 8'h01);
      chk(8'(sw_enabled), 8'h00);
      xfer(8'h03, 16'h00bc, 16'h0001, 1, 8'h08);
      xfer(8'h06, 16'h00bd, 16'h0033, 1, 8'h08);
      chk(slave_addr, 8'h01);
      // a two-cycle glitch must not enable commands
      sw = 1;
      repeat (2) tick();
      sw = 0;
      repeat (8) tick();
      chk(8'(sw_enabled), 8'h00);
      sw = 1;
      repeat (10) tick();
      chk(8'(sw_enabled), 8'h01);
      xfer(8'h03, 16'h00bc, 16'h0001, 2, 8'h01);
      repeat (3)
      begin
         rnd = lfsr(rnd);
         slow = rnd[0];
         xfer(8'h06, 16'h00bd, {8'h00, rnd}, 3, 8'h00);
         chk(slave_addr, rnd);
         xfer(8'h03, 16'h00bc, 16'h0001, 2, rnd);
      end
      xfer(8'h06, 16'h00bd, 16'h0100, 1, 8'h02);
      xfer(8'h06, 16'h00bd, 16'h0077, 0, 8'h04);
      chk(slave_addr, rnd);
      xfer(8'h03, 16'h00bc, 16'h0002, 1, 8'h02);
      xfer(8'h06, 16'h00bb, 16'h0000, 3, 8'h00);
      xfer(8'h06, 16'h00bb, 16'h0001, 1, 8'h02);
      xfer(8'h03, 16'h00bd, 16'h0001, 1, 8'h02);
      foreach (bad_fc[i])
         xfer(bad_fc[i], 16'h00bc, 16'h0001, 1, 8'h01);
      xfer(8'h03, 16'h00bc, 16'h0001, 0, 8'h01);
      xfer(8'h06, 16'h00bb, 16'h0000, 0, 8'h02);
      xfer(8'h06, 16'h00bb, 16'h0000, 0, 8'h03);
      chk(8'(pulses), 8'h01);
      stop_test();
   end
endmodule
